/* File: verilog/reset_seq_pkg.sv */
// Overview of operation
// - seven reset causes are told apart
// - uninitialised group never sees ordinary reset
// - ordinary reset on por, run resets, pin wake
// - sleep wdt/master_clear_pin resets only update status bits and pc low
// - status bits encode which reset occurred
// - every reset loads pc low with ones
// - run master clear clears status bits 7..5
// - sleep master clear gives 0001 0uuu
// - sleep watchdog gives 0000 0uuu
// - run watchdog gives 0000 uuuu
// - pin wake gives 1001 0uuu
// - comparator wake gives 0101 0uuu
// - calibration value loaded into accumulator bits 7..2
// - pin select bit enables external master clear
// - hold timer counts only while master clear high
// - leave reset one period after master clear high
// - core held in reset while hold timer active
// - long hold after power-on, short otherwise
// - status bit layout: 7,6 wake, 4 timeout, 3 powerdown
// - sleep sets timeout, clears powerdown; watchdog clears timeout
package reset_seq_pkg;

	localparam int AXI_AW = 8;

	localparam int CLK_HZ          = 20_000_000;
	localparam int POR_HOLD_MS     = 18;
	localparam int SUB_HOLD_US     = 10;
	localparam int POR_HOLD_CYCLES = (POR_HOLD_MS * CLK_HZ + 999) / 1000;
	localparam int SUB_HOLD_CYCLES = (SUB_HOLD_US * CLK_HZ + 999_999) / 1_000_000;
	localparam int HOLD_CNT_W      = 19;

	localparam logic [5:0] IDX_PCL    = 6'h02;
	localparam logic [5:0] IDX_STATUS = 6'h03;
	localparam logic [5:0] IDX_CONFIG = 6'h08;
	localparam logic [5:0] IDX_CAUSE  = 6'h09;

	localparam logic [7:0] PCL_RESET      = 8'hff;
	localparam logic [7:0] STATUS_POR     = 8'h18;
	localparam logic [7:0] STATUS_SW_MASK = 8'hc7;
	localparam logic [7:0] CONFIG_RESET   = 8'h01;

	localparam int PIN_WAKE_BIT  = 7;
	localparam int CMP_WAKE_BIT  = 6;
	localparam int TIMEOUT_BIT   = 4;
	localparam int POWERDOWN_BIT = 3;
	localparam int CFG_MASTER_CLEAR_PIN_BIT  = 0;
	localparam int CFG_CAL_LSB   = 2;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		ph_hold,
		ph_run,
		ph_sleep
	} phase_e;

	typedef enum logic [2:0] {
		cause_none,
		cause_por,
		cause_master_clear_pin_run,
		cause_master_clear_pin_sleep,
		cause_wdt_run,
		cause_wdt_sleep,
		cause_pin_wake,
		cause_cmp_wake
	} cause_e;

endpackage : reset_seq_pkg

/* File: verilog/reset_cause_and_startup_hold.sv */
module reset_cause_and_startup_hold #(
	parameter int POR_HOLD = reset_seq_pkg::POR_HOLD_CYCLES,
	parameter int SUB_HOLD = reset_seq_pkg::SUB_HOLD_CYCLES
) (
	input  wire logic                              core_clk,
	input  wire logic                              sys_rst,
	input  wire logic                              clk_en,
	input  wire logic                              master_clear_pin_n,
	input  wire logic                              watchdog_timeout,
	input  wire logic                              pin_wake_event,
	input  wire logic                              comparator_wake_event,
	input  wire logic                              sleep_enter,
	output logic                                   core_reset,
	output logic                                   ordinary_reset,
	output logic                                   accum_cal_load,
	output logic [5:0]                             accum_cal_value,
	output logic [7:0]                             program_counter_low,
	output logic [7:0]                             reset_cause_flags,
	output logic [2:0]                             reset_cause,
	input  wire logic [reset_seq_pkg::AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [31:0]                       s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [reset_seq_pkg::AXI_AW-1:0] s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [31:0]                            s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready
);
	import reset_seq_pkg::*;

	typedef struct packed {
		phase_e                phase;
		logic                  long_hold;
		logic [HOLD_CNT_W-1:0] hold_cnt;
		cause_e                cause;
		logic                  ordinary;
		logic                  accum_load;
		logic [7:0]            status;
		logic [7:0]            program_counter_low_byte;
		logic [7:0]            config_bits;
		logic                  aw_got;
		logic [5:0]            aw_idx;
		logic                  w_got;
		logic [31:0]           wdata;
		logic [3:0]            wstrb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
	} state_s;

	localparam logic [HOLD_CNT_W-1:0] POR_LAST = HOLD_CNT_W'(POR_HOLD - 1);
	localparam logic [HOLD_CNT_W-1:0] SUB_LAST = HOLD_CNT_W'(SUB_HOLD - 1);

	state_s cur_reg;
	state_s cur_next;
	logic   master_clear_pin_low;
	cause_e cause_now;

	// status update per reset cause
	function automatic logic [7:0] cause_status(input logic [7:0] s, input cause_e c);
		logic [7:0] r;
		r = s;
		case (c)
			cause_por:        r = STATUS_POR;
			cause_master_clear_pin_run:   r = {3'b000, s[4:0]};
			cause_master_clear_pin_sleep: r = {4'b0001, 1'b0, s[2:0]};
			cause_wdt_sleep:  r = {4'b0000, 1'b0, s[2:0]};
			cause_wdt_run:    r = {4'b0000, s[3:0]};
			cause_pin_wake:   r = {4'b1001, 1'b0, s[2:0]};
			cause_cmp_wake:   r = {4'b0101, 1'b0, s[2:0]};
			default:          r = s;
		endcase
		return r;
	endfunction : cause_status

	// pick the cause from phase and inputs
	function automatic cause_e pick_cause(input phase_e ph, input logic mc, input logic wd,
			input logic pw, input logic cw);
		cause_e c;
		c = cause_none;
		if (ph == ph_run) begin
			if (mc)
				c = cause_master_clear_pin_run;
			else if (wd)
				c = cause_wdt_run;
		end else if (ph == ph_sleep) begin
			if (mc)
				c = cause_master_clear_pin_sleep;
			else if (wd)
				c = cause_wdt_sleep;
			else if (pw)
				c = cause_pin_wake;
			else if (cw)
				c = cause_cmp_wake;
		end
		return c;
	endfunction : pick_cause

	assign master_clear_pin_low  = cur_reg.config_bits[CFG_MASTER_CLEAR_PIN_BIT] & ~master_clear_pin_n;
	assign cause_now = clk_en ? pick_cause(cur_reg.phase, master_clear_pin_low, watchdog_timeout,
		pin_wake_event, comparator_wake_event) : cause_none;

	// immediate assertion, clocked release
	assign core_reset = sys_rst | (cur_reg.phase == ph_hold) | (cause_now != cause_none);
	// uninitialised group is never wired to this
	assign ordinary_reset = sys_rst | ((cur_reg.phase == ph_hold) & cur_reg.ordinary);

	assign accum_cal_load      = cur_reg.accum_load;
	assign accum_cal_value     = cur_reg.config_bits[7:CFG_CAL_LSB];
	assign program_counter_low = cur_reg.program_counter_low_byte;
	assign reset_cause_flags   = cur_reg.status;
	assign reset_cause         = cur_reg.cause;

	assign s_axi_awready = ~cur_reg.aw_got & ~cur_reg.bvalid;
	assign s_axi_wready  = ~cur_reg.w_got & ~cur_reg.bvalid;
	assign s_axi_bvalid  = cur_reg.bvalid;
	assign s_axi_bresp   = cur_reg.bresp;
	assign s_axi_arready = ~cur_reg.rvalid;
	assign s_axi_rvalid  = cur_reg.rvalid;
	assign s_axi_rdata   = cur_reg.rdata;
	assign s_axi_rresp   = cur_reg.rresp;

	always_comb begin
		cur_next = cur_reg;
		if (clk_en) begin
			// write address and data, either order
			if (s_axi_awvalid && s_axi_awready) begin
				cur_next.aw_got = 1'b1;
				cur_next.aw_idx = s_axi_awaddr[7:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				cur_next.w_got = 1'b1;
				cur_next.wdata = s_axi_wdata;
				cur_next.wstrb = s_axi_wstrb;
			end
			if (cur_reg.bvalid && s_axi_bready)
				cur_next.bvalid = 1'b0;
			if (cur_reg.aw_got && cur_reg.w_got) begin
				cur_next.aw_got = 1'b0;
				cur_next.w_got  = 1'b0;
				cur_next.bvalid = 1'b1;
				cur_next.bresp  = RESP_OKAY;
				case (cur_reg.aw_idx)
					IDX_PCL: begin
						if (cur_reg.wstrb[0])
							cur_next.program_counter_low_byte = cur_reg.wdata[7:0];
					end
					IDX_STATUS: begin
						if (cur_reg.wstrb[0])
							cur_next.status = (cur_reg.status & ~STATUS_SW_MASK)
								| (cur_reg.wdata[7:0] & STATUS_SW_MASK);
					end
					IDX_CONFIG: begin
						if (cur_reg.wstrb[0])
							cur_next.config_bits = {cur_reg.wdata[7:2], 1'b0, cur_reg.wdata[0]};
					end
					IDX_CAUSE: begin
					end
					default: begin
						cur_next.bresp = RESP_SLVERR;
					end
				endcase
			end
			// read channel
			if (cur_reg.rvalid && s_axi_rready)
				cur_next.rvalid = 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				cur_next.rvalid = 1'b1;
				cur_next.rresp  = RESP_OKAY;
				cur_next.rdata  = 32'h0000_0000;
				case (s_axi_araddr[7:2])
					IDX_PCL:    cur_next.rdata[7:0] = cur_reg.program_counter_low_byte;
					IDX_STATUS: cur_next.rdata[7:0] = cur_reg.status;
					IDX_CONFIG: cur_next.rdata[7:0] = cur_reg.config_bits;
					IDX_CAUSE:  cur_next.rdata[7:0] = {cur_reg.ordinary, cur_reg.long_hold,
						cur_reg.phase, 1'b0, cur_reg.cause};
					default:    cur_next.rresp = RESP_SLVERR;
				endcase
			end
			// reset sequencing, hardware beats software writes
			cur_next.accum_load = 1'b0;
			case (cur_reg.phase)
				ph_hold: begin
					if (master_clear_pin_low) begin
						cur_next.hold_cnt = '0;
					end else if (cur_reg.hold_cnt == (cur_reg.long_hold ? POR_LAST : SUB_LAST)) begin
						cur_next.phase      = ph_run;
						cur_next.hold_cnt   = '0;
						cur_next.ordinary   = 1'b0;
						cur_next.accum_load = 1'b1;
					end else begin
						cur_next.hold_cnt = cur_reg.hold_cnt + 1'b1;
					end
				end
				ph_run, ph_sleep: begin
					if (cause_now != cause_none) begin
						cur_next.phase     = ph_hold;
						cur_next.long_hold = 1'b0;
						cur_next.hold_cnt  = '0;
						cur_next.cause     = cause_now;
						cur_next.status    = cause_status(cur_next.status, cause_now);
						cur_next.program_counter_low_byte       = PCL_RESET;
						// sleep wdt and master_clear_pin resume without reset state
						cur_next.ordinary  = (cause_now == cause_master_clear_pin_run) || (cause_now == cause_wdt_run)
							|| (cause_now == cause_pin_wake);
					end else if ((cur_reg.phase == ph_run) && sleep_enter) begin
						cur_next.phase                  = ph_sleep;
						cur_next.status[TIMEOUT_BIT]    = 1'b1;
						cur_next.status[POWERDOWN_BIT]  = 1'b0;
					end
				end
				default: begin
					cur_next.phase = ph_hold;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cur_reg.phase       <= ph_hold;
			cur_reg.long_hold   <= 1'b1;
			cur_reg.hold_cnt    <= '0;
			cur_reg.cause       <= cause_por;
			cur_reg.ordinary    <= 1'b1;
			cur_reg.accum_load  <= 1'b0;
			cur_reg.status      <= STATUS_POR;
			cur_reg.program_counter_low_byte         <= PCL_RESET;
			cur_reg.config_bits <= CONFIG_RESET;
			cur_reg.aw_got      <= 1'b0;
			cur_reg.aw_idx      <= 6'h00;
			cur_reg.w_got       <= 1'b0;
			cur_reg.wdata       <= 32'h0000_0000;
			cur_reg.wstrb       <= 4'h0;
			cur_reg.bvalid      <= 1'b0;
			cur_reg.bresp       <= RESP_OKAY;
			cur_reg.rvalid      <= 1'b0;
			cur_reg.rdata       <= 32'h0000_0000;
			cur_reg.rresp       <= RESP_OKAY;
		end else begin
			cur_reg <= cur_next;
		end
	end

endmodule : reset_cause_and_startup_hold

/* File: verif/reset_seq_properties.sv */
module reset_seq_props #(
	parameter int POR_HOLD = 50,
	parameter int SUB_HOLD = 10
) (
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       clk_en,
	input wire logic       master_clear_pin_n,
	input wire logic       watchdog_timeout,
	input wire logic       pin_wake_event,
	input wire logic       comparator_wake_event,
	input wire logic       sleep_enter,
	input wire logic       core_reset,
	input wire logic       accum_cal_load,
	input wire logic [7:0] program_counter_low,
	input wire logic [7:0] reset_cause_flags,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready
);
	timeunit 1ns;
	timeprecision 1ns;
	int   hold_cnt;
	logic por_flag;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);
	// counts held cycles with master clear released
	always_ff @(posedge core_clk) begin
		if (sys_rst || !core_reset || !master_clear_pin_n) hold_cnt <= 0;
		else if (clk_en) hold_cnt <= hold_cnt + 1;
		if (sys_rst) por_flag <= 1'b1;
		else if (!core_reset) por_flag <= 1'b0;
	end
	pcl_all_ones_a: assert property ($rose(core_reset) |=> program_counter_low == 8'hff)
		else $error("pc low not all ones after reset");
	arith_kept_a: assert property ($rose(core_reset) |=> reset_cause_flags[2:0] == $past(reset_cause_flags[2:0]))
		else $error("arithmetic flags changed by reset");
	wdt_flags_a: assert property ($rose(core_reset) && watchdog_timeout && master_clear_pin_n
		|=> reset_cause_flags[7:4] == 4'h0)
		else $error("watchdog reset flags wrong");
	pin_wake_a: assert property ($rose(core_reset) && pin_wake_event && !watchdog_timeout && master_clear_pin_n
		|=> reset_cause_flags[7:3] == 5'b10010)
		else $error("pin wake flags wrong");
	cmp_wake_a: assert property ($rose(core_reset) && comparator_wake_event && !pin_wake_event && !watchdog_timeout
		&& master_clear_pin_n |=> reset_cause_flags[7:3] == 5'b01010)
		else $error("comparator wake flags wrong");
	sleep_flags_a: assert property (sleep_enter && clk_en && !core_reset && master_clear_pin_n && !watchdog_timeout
		&& !pin_wake_event && !comparator_wake_event |=> reset_cause_flags[4:3] == 2'b10)
		else $error("sleep entry flags wrong");
	cal_pulse_a: assert property (accum_cal_load |-> $past(core_reset) && !core_reset ##1 !accum_cal_load)
		else $error("calibration load pulse misplaced");
	master_clear_pin_holds_a: assert property (core_reset && !master_clear_pin_n |=> core_reset)
		else $error("left reset with master clear low");
	por_hold_a: assert property ($fell(core_reset) && por_flag |-> hold_cnt inside {[POR_HOLD-1:POR_HOLD+3]})
		else $error("power-on hold length wrong");
	sub_hold_a: assert property ($fell(core_reset) && !por_flag |-> hold_cnt inside {[SUB_HOLD-1:SUB_HOLD+3]})
		else $error("short hold length wrong");
	cover property ($fell(core_reset) && !por_flag);
	cover property (accum_cal_load);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule : reset_seq_props

bind reset_cause_and_startup_hold reset_seq_props #(.POR_HOLD(POR_HOLD), .SUB_HOLD(SUB_HOLD)) reset_seq_props_i (.*);

/* File: verif/core_side_model.sv */
module core_side_model (
	input  wire logic       core_clk,
	input  wire logic       accum_cal_load,
	input  wire logic [5:0] accum_cal_value,
	input  wire logic [2:0] req,
	output logic            sleep_enter = 1'b0,
	output logic            watchdog_timeout = 1'b0,
	output logic            pin_wake_event = 1'b0,
	output logic            comparator_wake_event = 1'b0,
	output wire logic       master_clear_pin_n,
	output logic [7:0]      accum
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] low_cnt = 3'h0;
	// pin idles at its pull-up level
	assign master_clear_pin_n = (low_cnt == 3'h0);
	always @(posedge core_clk) begin
		sleep_enter <= (req == 3'h1);
		watchdog_timeout <= (req == 3'h2);
		pin_wake_event <= (req == 3'h3);
		comparator_wake_event <= (req == 3'h4);
		if (req == 3'h5) low_cnt <= 3'h4;
		else if (low_cnt != 3'h0) low_cnt <= low_cnt - 3'h1;
		if (accum_cal_load) accum <= {accum_cal_value, 2'b00};
	end
endmodule : core_side_model

/* File: verif/tb.sv */
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import reset_seq_pkg::*;
	logic        core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
	logic        master_clear_pin_n, watchdog_timeout, pin_wake_event, comparator_wake_event, sleep_enter;
	logic        core_reset, ordinary_reset, accum_cal_load;
	logic [5:0]  accum_cal_value;
	logic [7:0]  program_counter_low, reset_cause_flags, accum;
	logic [2:0]  reset_cause, req = 3'h0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h1;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          n_fail = 0, n_checks = 0;
	logic [2:0]  ev_t [6] = '{3'h2, 3'h2, 3'h5, 3'h5, 3'h3, 3'h4};
	logic        sl_t [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
	logic        od_t [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [7:0]  pre_t [6] = '{8'hc5, 8'h05, 8'h05, 8'hc5, 8'h05, 8'h05};
	logic [7:0]  st_t [6] = '{8'h0d, 8'h05, 8'h15, 8'h15, 8'h95, 8'h55};
	cause_e      cs_t [6] = '{cause_wdt_run, cause_wdt_sleep, cause_master_clear_pin_sleep, cause_master_clear_pin_run, cause_pin_wake,
		cause_cmp_wake};

	reset_cause_and_startup_hold #(.POR_HOLD(50), .SUB_HOLD(10)) reset_cause_and_startup_hold_i (.*);
	core_side_model core_side_model_i (.*);

	always #25 core_clk = ~core_clk;

	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic axi(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd,
		output logic [1:0] rs);
		int   n;
		logic ah, wh, arh, dn;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= we;
		s_axi_wvalid <= we;
		s_axi_bready <= we;
		s_axi_arvalid <= !we;
		s_axi_rready <= !we;
		n = 0;
		dn = 1'b0;
		while (!dn && n < 100) begin
			@(negedge core_clk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			arh = s_axi_arvalid && s_axi_arready;
			dn = we ? s_axi_bvalid : s_axi_rvalid;
			rd = s_axi_rdata[7:0];
			rs = we ? s_axi_bresp : s_axi_rresp;
			@(posedge core_clk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			if (arh) s_axi_arvalid <= 1'b0;
			if (dn) begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
			end
			n++;
		end
		if (!dn) begin
			n_fail++;
			close_out();
		end
	endtask : axi

	task automatic fire(input logic [2:0] c);
		@(posedge core_clk);
		req <= c;
		@(posedge core_clk);
		req <= 3'h0;
	endtask : fire

	task automatic wait_run;
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (core_reset !== 1'b0 && n < 2000);
		if (n >= 2000) begin
			n_fail++;
			close_out();
		end
	endtask : wait_run

	initial begin
		logic [7:0] rd;
		logic [1:0] rs;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		wait_run();
		axi(1'b0, 8'h0c, 8'h00, rd, rs);
		chk(rd, 8'h18);
		axi(1'b0, 8'h3c, 8'h00, rd, rs);
		chk({rs, rd}, {RESP_SLVERR, 8'h00});
		axi(1'b1, 8'h20, 8'had, rd, rs);
		chk(rs, RESP_OKAY);
		for (int i = 0; i < 6; i++) begin
			axi(1'b1, 8'h0c, pre_t[i], rd, rs);
			axi(1'b1, 8'h08, 8'h12, rd, rs);
			if (sl_t[i]) begin
				fire(3'h1);
				repeat (3) @(posedge core_clk);
			end
			fire(ev_t[i]);
			repeat (4) @(negedge core_clk);
			chk(ordinary_reset, od_t[i]);
			chk(reset_cause, cs_t[i]);
			wait_run();
			axi(1'b0, 8'h0c, 8'h00, rd, rs);
			chk(rd, st_t[i]);
			axi(1'b0, 8'h08, 8'h00, rd, rs);
			chk(rd, 8'hff);
			chk(accum[7:2], 6'h2b);
		end
		axi(1'b1, 8'h20, 8'hac, rd, rs);
		fire(3'h5);
		repeat (6) @(negedge core_clk);
		chk(core_reset, 1'b0);
		chk(reset_cause, cause_cmp_wake);
		@(posedge core_clk);
		clk_en <= 1'b0;
		fire(3'h2);
		repeat (3) @(negedge core_clk);
		chk(core_reset, 1'b0);
		@(posedge core_clk);
		clk_en <= 1'b1;
		axi(1'b0, 8'h24, 8'h00, rd, rs);
		chk(rd, {1'b0, 1'b0, 2'b01, 1'b0, 3'h7});
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		wait_run();
		chk(reset_cause, cause_por);
		axi(1'b0, 8'h0c, 8'h00, rd, rs);
		chk(rd, 8'h18);
		close_out();
	end
endmodule : tb
